// >>> lvd_glitch_map.svh
/*
  constants for the lvd release glitch guard: timing figures and counts.
  assumes a 100 MHz core clock; included by bare name.
*/
`ifndef LVD_GLITCH_MAP_SVH
`define LVD_GLITCH_MAP_SVH

// core clock period and settle delay figure
`define CLK_PERIOD_NS 10
`define SETTLE_NS 400
// settle delay in cycles: least time, rounded up
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// windows in half settle delays
`define REQ_HOLD_HALVES 5
`define REQ_IGNORE_HALVES 3
`define CNT_W 12

`endif

// >>> lvd_glitch_pkg.sv
/*
  types shared by the lvd release glitch guard.
  assumes nothing beyond a SystemVerilog compiler.
*/
package lvd_glitch_pkg;
  // target release sequence, gray coded along the usual path
  typedef enum logic [1:0]
  {
    TGT_IDLE = 2'b00,
    TGT_CONN = 2'b01,
    TGT_HOLD = 2'b11,
    TGT_DONE = 2'b10
  } tgt_state_t;
endpackage

// >>> lvd_glitch_if.sv
/*
  interface carrying a timed window request between guard and timer.
  assumes one clock domain.
*/
`timescale 1ns/1ns
interface lvd_timer_if;
  logic start;
  logic [11:0] limit;
  logic expired;
  modport ctrl (output start, output limit, input expired);
  modport tmr (input start, input limit, output expired);
endinterface

// >>> lvd_window_timer.sv
/*
  one-shot window timer: start loads the limit, expired pulses at zero.
  assumes start is a single-cycle pulse from the same clock.
*/
`timescale 1ns/1ns
module lvd_window_timer
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  lvd_timer_if.tmr t
);
  logic [11:0] cnt_ff;
  logic run_ff;
  logic exp_ff;
  wire logic at_one = run_ff && (cnt_ff == 12'h001);

  // restart wins over a running count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_ff <= 12'h000;
      run_ff <= 1'b0;
      exp_ff <= 1'b0;
    end
    else if (ce)
    begin
      exp_ff <= t.start ? 1'b0 : at_one;
      run_ff <= t.start ? 1'b1 : (run_ff && !at_one);
      cnt_ff <= t.start ? t.limit : (run_ff ? cnt_ff - 12'h001 : cnt_ff);
    end
  end
  assign t.expired = exp_ff;
endmodule // lvd_window_timer

// >>> lvd_release_glitch_guard.sv
/*
  release glitch guard: sequences release of actively negated control
  lines and blanks ack/atn/req reception after bsy drops.
  assumes bus levels are true-high and already decoded from pins; the
  surrounding phase logic supplies role, phase and wanted drive values.
*/
`timescale 1ns/1ns
`include "lvd_glitch_map.svh"

// What this block does
// - release glitches last up to one settle delay
// - lvd drivers force all glitch handling on
// - initiator keeps ack/atn negated until bus free
// - target ignores ack/atn after bsy release
// - target holds req negated 2.5 settle delays
// - initiator ignores req within 1.5 settle delays
// - target keeps c/d, i/o, msg until bsy released
// - bus free starts settle delay after bsy/sel false
// - active negation per signal class and phase
module lvd_release_glitch_guard
#(
  parameter logic [11:0] SETTLE_CYC = 12'(`SETTLE_CYC),
  parameter int DATA_W = 8
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic lvd_mode,
  input wire logic guard_opt,
  input wire logic role_target,
  input wire logic in_selection,
  input wire logic in_info_xfer,
  input wire logic bsy_drive_req,
  input wire logic ctl_release_req,
  input wire logic bsy_pin,
  input wire logic sel_pin,
  input wire logic ack_pin,
  input wire logic atn_pin,
  input wire logic req_pin,
  input wire logic connect_evt,
  input wire logic [DATA_W-1:0] data_out,
  output logic bsy_oe,
  output logic sel_oe,
  output logic rst_oe,
  output logic acknak_neg_oe,
  output logic req_neg_oe,
  output logic phase_oe,
  output logic [DATA_W-1:0] data_oe,
  output logic ack_seen,
  output logic atn_seen,
  output logic req_seen,
  output logic bus_free
);
  // reset release through two flops
  logic rs1_ff;
  logic rs2_ff;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rs1_ff <= 1'b0;
      rs2_ff <= 1'b0;
    end
    else
    begin
      rs1_ff <= 1'b1;
      rs2_ff <= rs1_ff;
    end
  end
  wire logic rst_n = rs2_ff;

  // pin inputs: three flops, change accepted when stages 2 and 3 agree
  localparam int NPIN = 5;
  wire logic [NPIN-1:0] pin_raw = {bsy_pin, sel_pin, ack_pin, atn_pin,
                                   req_pin};
  logic [NPIN-1:0] s1_ff;
  logic [NPIN-1:0] s2_ff;
  logic [NPIN-1:0] s3_ff;
  logic [NPIN-1:0] pin_ff;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          s1_ff[gi] <= 1'b0;
          s2_ff[gi] <= 1'b0;
          s3_ff[gi] <= 1'b0;
          pin_ff[gi] <= 1'b0;
        end
        else if (ce)
        begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi])
            pin_ff[gi] <= s3_ff[gi];
        end
      end
    end
  endgenerate
  wire logic bsy_s = pin_ff[4];
  wire logic sel_s = pin_ff[3];
  wire logic ack_s = pin_ff[2];
  wire logic atn_s = pin_ff[1];
  wire logic req_s = pin_ff[0];

  // guard enable: mandatory under lvd, optional otherwise
  wire logic guard_on = lvd_mode || guard_opt;

  // bsy edge seen on the bus and our own bsy release
  logic bsy_prev_ff;
  logic bsy_oe_ff;
  wire logic bus_bsy_fall = bsy_prev_ff && !bsy_s;
  wire logic own_bsy_rel = bsy_oe_ff && !bsy_drive_req;

  // three window timers: bus free, req hold, req ignore
  lvd_timer_if free_t();
  lvd_timer_if hold_t();
  lvd_timer_if ign_t();
  wire logic bus_idle = !bsy_s && !sel_s;
  logic idle_prev_ff;
  // half settle delay rounded so 2.5x never falls short, 1.5x never long
  wire logic [12:0] settle_x5 = 13'(SETTLE_CYC) * 13'd5;
  wire logic [12:0] settle_x3 = 13'(SETTLE_CYC) * 13'd3;
  assign free_t.start = bus_idle && !idle_prev_ff;
  assign free_t.limit = SETTLE_CYC;
  assign hold_t.start = own_bsy_rel && role_target;
  assign hold_t.limit = settle_x5[12:1] + {11'h000, settle_x5[0]};
  assign ign_t.start = bus_bsy_fall && !role_target;
  assign ign_t.limit = settle_x3[12:1];

  lvd_window_timer u_free
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .t(free_t)
  );
  lvd_window_timer u_hold
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .t(hold_t)
  );
  lvd_window_timer u_ign
  (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .t(ign_t)
  );

  // target release sequence
  lvd_glitch_pkg::tgt_state_t tst_ff;
  lvd_glitch_pkg::tgt_state_t nxt_tst;
  always_comb
  begin
    nxt_tst = tst_ff;
    case (tst_ff)
      lvd_glitch_pkg::TGT_IDLE:
        if (role_target && bsy_drive_req)
          nxt_tst = lvd_glitch_pkg::TGT_CONN;
      lvd_glitch_pkg::TGT_CONN:
        if (own_bsy_rel)
          nxt_tst = lvd_glitch_pkg::TGT_HOLD;
      lvd_glitch_pkg::TGT_HOLD:
        if (hold_t.expired)
          nxt_tst = lvd_glitch_pkg::TGT_DONE;
      lvd_glitch_pkg::TGT_DONE:
        nxt_tst = lvd_glitch_pkg::TGT_IDLE;
      default:
        nxt_tst = lvd_glitch_pkg::TGT_IDLE;
    endcase
  end

  // blanking flags; ack/atn set on our bsy release, req on bsy falling on the bus, cleared by a new connection
  logic ackatn_ign_ff;
  logic req_ign_ff;
  logic free_ff;
  // a settle delay after idle is bus free; any bsy/sel ends it
  wire logic nxt_free = bus_idle && (free_ff || free_t.expired);
  // target: blank within one settle delay, here on the very next edge
  wire logic nxt_ackatn_ign = guard_on && role_target &&
    (own_bsy_rel || (ackatn_ign_ff && !connect_evt));
  // initiator: blank at once, well inside 1.5 settle delays
  wire logic nxt_req_ign = guard_on && !role_target &&
    (bus_bsy_fall || (req_ign_ff && !connect_evt));

  // drive enables
  wire logic hold_req = guard_on && (tst_ff == lvd_glitch_pkg::TGT_HOLD);
  wire logic nxt_req_neg = role_target && in_info_xfer ||
    hold_req || (own_bsy_rel && guard_on);
  // initiator negates ack/atn during transfers and until bus free
  wire logic nxt_acknak = !role_target &&
    (in_info_xfer || (guard_on && acknak_neg_oe && !free_ff));
  // phase lines stay driven while bsy is driven
  wire logic nxt_phase = role_target && (bsy_drive_req ||
    (!ctl_release_req && in_info_xfer));
  // selection: only true bits driven, false ones released
  wire logic [DATA_W-1:0] nxt_data_oe = in_selection ? data_out :
    (in_info_xfer ? {DATA_W{1'b1}} : {DATA_W{1'b0}});

  // registered state and outputs; bsy/sel/rst never actively negated,
  // their enables only ever mean assert
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tst_ff <= lvd_glitch_pkg::TGT_IDLE;
      bsy_prev_ff <= 1'b0;
      idle_prev_ff <= 1'b1;
      bsy_oe_ff <= 1'b0;
      ackatn_ign_ff <= 1'b0;
      req_ign_ff <= 1'b0;
      free_ff <= 1'b0;
      acknak_neg_oe <= 1'b0;
      req_neg_oe <= 1'b0;
      phase_oe <= 1'b0;
      data_oe <= '0;
      ack_seen <= 1'b0;
      atn_seen <= 1'b0;
      req_seen <= 1'b0;
    end
    else if (ce)
    begin
      tst_ff <= nxt_tst;
      bsy_prev_ff <= bsy_s;
      idle_prev_ff <= bus_idle;
      bsy_oe_ff <= bsy_drive_req;
      ackatn_ign_ff <= nxt_ackatn_ign;
      req_ign_ff <= nxt_req_ign;
      free_ff <= nxt_free;
      acknak_neg_oe <= nxt_acknak;
      req_neg_oe <= nxt_req_neg;
      phase_oe <= nxt_phase;
      data_oe <= nxt_data_oe;
      ack_seen <= ack_s && !nxt_ackatn_ign;
      atn_seen <= atn_s && !nxt_ackatn_ign;
      req_seen <= req_s && !nxt_req_ign;
    end
  end
  assign bsy_oe = bsy_oe_ff;
  assign sel_oe = 1'b0;
  assign rst_oe = 1'b0;
  assign bus_free = free_ff;

  // hold counter for checking the req window length
  logic [12:0] rel_cnt_ff;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rel_cnt_ff <= 13'h0000;
    else if (ce)
      rel_cnt_ff <= hold_t.start ? 13'h0001 :
        (rel_cnt_ff != 13'h0000 ? rel_cnt_ff + 13'h0001 : 13'h0000);
  end

  property p_req_hold;
    @(posedge clk) disable iff (!rst_n)
    (ce && guard_on && rel_cnt_ff != 13'h0000 &&
     rel_cnt_ff < hold_t.limit + 13'h0001) |-> req_neg_oe;
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("req released before hold ended");

  property p_ackatn_ign;
    @(posedge clk) disable iff (!rst_n)
    (ce && guard_on && role_target && own_bsy_rel) |=> ackatn_ign_ff;
  endproperty
  a_ackatn_ign: assert property (p_ackatn_ign)
    else $error("ack/atn not blanked after bsy release");

  property p_ack_blank;
    @(posedge clk) disable iff (!rst_n)
    ackatn_ign_ff |-> !ack_seen && !atn_seen;
  endproperty
  a_ack_blank: assert property (p_ack_blank)
    else $error("ack or atn seen while blanked");

  property p_req_ign;
    @(posedge clk) disable iff (!rst_n)
    (ce && guard_on && !role_target && bus_bsy_fall) |=> req_ign_ff;
  endproperty
  a_req_ign: assert property (p_req_ign)
    else $error("req not blanked after bsy fall");

  property p_free_late;
    @(posedge clk) disable iff (!rst_n)
    $rose(bus_idle) |-> !free_ff [*2];
  endproperty
  a_free_late: assert property (p_free_late)
    else $error("bus free declared too early");

  property p_acknak;
    @(posedge clk) disable iff (!rst_n)
    (ce && guard_on && acknak_neg_oe && !free_ff && !role_target)
      |=> acknak_neg_oe || !ce;
  endproperty
  a_acknak: assert property (p_acknak)
    else $error("ack/atn released before bus free");

  // phase lines may drop on the same edge as bsy, never before it
  property p_phase;
    @(posedge clk) disable iff (!rst_n)
    (bsy_oe_ff && role_target) |-> phase_oe;
  endproperty
  a_phase: assert property (p_phase)
    else $error("phase lines released while bsy driven");

  property p_sel_data;
    @(posedge clk) disable iff (!rst_n)
    (ce && in_selection) |=> ((data_oe & ~$past(data_out)) == '0) || !ce;
  endproperty
  a_sel_data: assert property (p_sel_data)
    else $error("false data bit driven in selection");

  property p_no_neg;
    @(posedge clk) disable iff (!rst_n)
    !sel_oe && !rst_oe;
  endproperty
  a_no_neg: assert property (p_no_neg)
    else $error("sel or rst negated actively");

  c_hold_done: cover property (@(posedge clk) hold_t.expired);
  c_bus_free: cover property (@(posedge clk) $rose(free_ff));
  c_req_blank: cover property (@(posedge clk) $rose(req_ign_ff));
  c_ack_blank: cover property (@(posedge clk) $rose(ackatn_ign_ff));
  c_req_window: cover property (@(posedge clk) ign_t.expired && req_ign_ff);
endmodule // lvd_release_glitch_guard

// >>> lvd_bus_partner.sv
/*
  far side bus model: the other devices sharing the bus, as wired-or
  true-high levels, with a release glitch generator on ack/atn/req.
  assumes terminators bias released lines to false.
*/
`timescale 1ns/1ns
module lvd_bus_partner
#(
  parameter int GLITCH_CYC = 4
)
(
  input wire logic clk,
  input wire logic dut_bsy_oe,
  input wire logic dut_sel_oe,
  input wire logic far_bsy,
  input wire logic far_sel,
  input wire logic far_ack,
  input wire logic far_atn,
  input wire logic far_req,
  input wire logic glitch_go,
  output logic bsy_pin,
  output logic sel_pin,
  output logic ack_pin,
  output logic atn_pin,
  output logic req_pin
);
  int glitch_ff = 0;
  logic glitching;

  // worst case glitch: a whole settle delay, not a short blip
  always_ff @(posedge clk)
    glitch_ff <= glitch_go ? GLITCH_CYC :
      (glitch_ff > 0 ? glitch_ff - 1 : 0);
  assign glitching = (glitch_ff > 0);

  // released lines fall to the bias level, false
  assign bsy_pin = dut_bsy_oe | far_bsy;
  assign sel_pin = dut_sel_oe | far_sel;
  assign ack_pin = far_ack | glitching;
  assign atn_pin = far_atn | glitching;
  assign req_pin = far_req | glitching;
endmodule // lvd_bus_partner

// >>> tb_lvd_release_glitch_guard.sv
/*
  self-checking bench for the release glitch guard, settle delay of 4.
  assumes the partner model in lvd_bus_partner.sv.
*/
`timescale 1ns/1ns
module tb_lvd_release_glitch_guard;
  localparam int SC = 4;
  logic clk = 1'b0;
  logic reset_n, lvd_mode, guard_opt, role_target, in_selection;
  logic in_info_xfer, bsy_drive_req, ctl_release_req, connect_evt;
  logic far_bsy, far_sel, far_ack, far_atn, far_req, glitch_go;
  logic bsy_pin, sel_pin, ack_pin, atn_pin, req_pin;
  logic [7:0] data_out, data_oe;
  logic bsy_oe, sel_oe, rst_oe, acknak_neg_oe, req_neg_oe, phase_oe;
  logic ack_seen, atn_seen, req_seen, bus_free;
  int error_cnt = 0;
  int num_checks = 0;

  always #5 clk = ~clk;

  lvd_release_glitch_guard #(.SETTLE_CYC(12'h004), .DATA_W(8)) i_dut
  (
    .clk(clk), .reset_n(reset_n), .ce(1'b1), .lvd_mode(lvd_mode),
    .guard_opt(guard_opt), .role_target(role_target),
    .in_selection(in_selection), .in_info_xfer(in_info_xfer),
    .bsy_drive_req(bsy_drive_req), .ctl_release_req(ctl_release_req),
    .bsy_pin(bsy_pin), .sel_pin(sel_pin), .ack_pin(ack_pin),
    .atn_pin(atn_pin), .req_pin(req_pin), .connect_evt(connect_evt),
    .data_out(data_out), .bsy_oe(bsy_oe), .sel_oe(sel_oe),
    .rst_oe(rst_oe), .acknak_neg_oe(acknak_neg_oe),
    .req_neg_oe(req_neg_oe), .phase_oe(phase_oe), .data_oe(data_oe),
    .ack_seen(ack_seen), .atn_seen(atn_seen), .req_seen(req_seen),
    .bus_free(bus_free)
  );

  lvd_bus_partner #(.GLITCH_CYC(SC)) i_far
  (
    .clk(clk), .dut_bsy_oe(bsy_oe), .dut_sel_oe(sel_oe),
    .far_bsy(far_bsy), .far_sel(far_sel), .far_ack(far_ack),
    .far_atn(far_atn), .far_req(far_req), .glitch_go(glitch_go),
    .bsy_pin(bsy_pin), .sel_pin(sel_pin), .ack_pin(ack_pin),
    .atn_pin(atn_pin), .req_pin(req_pin)
  );

  task automatic check(input string name, input logic [7:0] got,
                       input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic final_report();
    if (error_cnt == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic pulse_connect();
    connect_evt = 1'b1;
    tick(1);
    connect_evt = 1'b0;
  endtask

  // a glitch a settle delay long must never reach the blanked output
  task automatic glitch_blanked(input logic blank);
    logic seen;
    seen = 1'b0;
    glitch_go = 1'b1;
    tick(1);
    glitch_go = 1'b0;
    repeat (12)
    begin
      // a target listens to ack/atn, an initiator to req; the driven
      // line of each role is not blanked and must not be judged here
      seen = seen | (role_target ? (ack_seen | atn_seen) : req_seen);
      tick(1);
    end
    check("glitch seen", seen, !blank);
  endtask

  task automatic t_selection();
    in_selection = 1'b1;
    data_out = 8'ha5;
    tick(4);
    check("data_oe", data_oe, 8'ha5);
    check("sel_oe", sel_oe, 8'h00);
    check("rst_oe", rst_oe, 8'h00);
    in_selection = 1'b0;
  endtask

  task automatic t_target();
    int n;
    role_target = 1'b1;
    lvd_mode = 1'b1;
    far_ack = 1'b1;
    far_atn = 1'b1;
    bsy_drive_req = 1'b1;
    pulse_connect();
    tick(8);
    check("ack_seen", ack_seen, 8'h01);
    ctl_release_req = 1'b1;
    tick(6);
    check("phase_oe", phase_oe, 8'h01);
    bsy_drive_req = 1'b0;
    tick(1);
    check("bsy_oe", bsy_oe, 8'h00);
    n = 0;
    while (req_neg_oe === 1'b1 && n < 40)
    begin
      if (n == SC)
        check("ack blank", {ack_seen, atn_seen}, 8'h00);
      tick(1);
      n++;
    end
    check("req hold", 8'(n >= 10 && n <= 14), 8'h01);
    glitch_blanked(1'b1);
    pulse_connect();
    n = 0;
    while (ack_seen !== 1'b1 && n < 10)
    begin
      tick(1);
      n++;
    end
    if (n == 10)
    begin
      error_cnt++;
      $display("BAD ack_seen expected 1 seen timeout");
      final_report();
    end
    far_ack = 1'b0;
    far_atn = 1'b0;
    ctl_release_req = 1'b0;
  endtask

  // one initiator disconnect per guard setting
  task automatic t_initiator(input logic lvd, input logic opt);
    int n;
    role_target = 1'b0;
    lvd_mode = lvd;
    guard_opt = opt;
    far_bsy = 1'b1;
    far_req = 1'b1;
    in_info_xfer = 1'b1;
    pulse_connect();
    tick(8);
    check("acknak_neg_oe", acknak_neg_oe, 8'h01);
    check("data_oe xfer", data_oe, 8'hff);
    check("req_seen", req_seen, 8'h01);
    in_info_xfer = 1'b0;
    far_req = 1'b0;
    far_bsy = 1'b0;
    n = 0;
    while (bus_free !== 1'b1 && n < 40)
    begin
      if (lvd | opt)
        check("ack negated", acknak_neg_oe, 8'h01);
      tick(1);
      n++;
    end
    check("bus free delay", 8'(n >= 5 && n <= 11), 8'h01);
    glitch_blanked(lvd | opt);
  endtask

  initial
  begin
    {reset_n, lvd_mode, guard_opt, role_target, in_selection} = 5'h00;
    {in_info_xfer, bsy_drive_req, ctl_release_req, connect_evt} = 4'h0;
    {far_bsy, far_sel, far_ack, far_atn, far_req, glitch_go} = 6'h00;
    data_out = 8'h00;
    tick(4);
    reset_n = 1'b1;
    tick(3);
    check("outputs after reset", {bsy_oe, req_neg_oe, phase_oe, bus_free},
          8'h00);
    t_selection();
    t_target();
    t_initiator(1'b1, 1'b0);
    t_initiator(1'b0, 1'b1);
    t_initiator(1'b0, 1'b0);
    final_report();
  end
endmodule // tb_lvd_release_glitch_guard
